//--- rtl/cft_defines.svh
// Constants for the correlator frame timing block
// Operation
// - Frame boundary pulse repeats every n*125000 samples, n from 1 to 256.
// - Frame boundary pulse stays high for exactly 256 active samples.
// - Accumulate strobe pulses every 2^n samples; n of 0 holds it high.
// - Accumulate strobe is high on first sample after boundary falls.
// - Shift strobe pulses every 2^n samples; n of 0 holds it high.
// - Shift strobe is high on first sample after boundary falls.
// - Formatter source brings four 2-bit channels plus its second tick.
// - Decoded bit replaces upper sideband input; magnitude held constant.
// - Timing works with decoded streams up to 16 Mbit/s.
// - Decoder clock idles in parity bits; only real edges count.
// - No correlator frame is ever shortened, errors or not.
// - Frames realign to the tick and flywheel when ticks are missing.
// - Buffer activity disables correlator; correlator use blocks buffer.
// - Only one decoder is routed to the correlator at a time.
// - State-count mode copies one stream and gates validity by state.
`ifndef CFT_DEFINES_SVH
`define CFT_DEFINES_SVH
`define CFT_OFF_CTRL 8'h00
`define CFT_OFF_PERIOD 8'h04
`define CFT_OFF_STROBE 8'h08
`define CFT_OFF_STATUS 8'h0c
`define CFT_OFF_FRAMES 8'h10
`define CFT_CTRL_RUN 0
`define CFT_CTRL_SRC 2:1
`define CFT_CTRL_MAG 3
`define CFT_CTRL_STC 4
`define CFT_CTRL_CH 6:5
`define CFT_CTRL_CLEAR 7
`define CFT_CTRL_RST 8'h00
`define CFT_PERIOD_RST 8'h00
`define CFT_STROBE_RST 8'h00
`define CFT_ACC_N 2:0
`define CFT_SHF_N 6:4
`define CFT_FRAME_UNIT 125000
`define CFT_PULSE_LEN 25'h0000100
`define CFT_CNT_W 25
`define CFT_SYNC_W 16
`define CFT_V_FCLK 0
`define CFT_V_FTICK 1
`define CFT_V_FSIGN 5:2
`define CFT_V_FMAG 9:6
`define CFT_V_DECA 12:10
`define CFT_V_DECB 15:13
`endif

//--- rtl/cft_pkg.sv
// Types for the correlator frame timing block
`include "cft_defines.svh"
package cft_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } cft_state_t;
  typedef enum logic [1:0] {
    SRC_FMT = 2'h0,
    SRC_DEC_A = 2'h1,
    SRC_DEC_B = 2'h2
  } cft_src_t;
  typedef struct packed {
    logic [`CFT_SYNC_W-1:0] meta;
    logic [`CFT_SYNC_W-1:0] stable;
  } cft_sync_t;
  typedef struct packed {
    logic [6:0] phase;
    logic strobe;
  } cft_strobe_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] period;
    logic [7:0] strobe_cfg;
    logic [31:0] rdata;
    cft_state_t state;
    logic [`CFT_CNT_W-1:0] cnt;
    logic [`CFT_CNT_W-1:0] phase;
    logic [8:0] cur_n;
    logic clk_prev;
    logic tick_prev;
    logic tick_pend;
    logic realign;
    logic aligned;
    logic fbp;
    logic [15:0] frames;
    logic [7:0] resyncs;
    logic [3:0] mux_sign;
    logic [3:0] mux_mag;
    logic [3:0] mux_valid;
    logic sample;
    logic clr;
  } cft_core_t;
endpackage : cft_pkg

//--- rtl/cft_sync.sv
// Two-stage synchroniser for the asynchronous link pins
`timescale 1ns/1ps
`default_nettype none
`include "cft_defines.svh"
module cft_sync
  import cft_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`CFT_SYNC_W-1:0] async_in,
  output logic [`CFT_SYNC_W-1:0] sync_out
);
  cft_sync_t r_q;
  cft_sync_t r_d;

  always_comb
  begin
    r_d.meta = async_in;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign sync_out = r_q.stable;
endmodule : cft_sync
`default_nettype wire

//--- rtl/cft_strobe_gen.sv
// Power-of-two strobe generator phased to a restart sample
`timescale 1ns/1ps
`default_nettype none
module cft_strobe_gen
  import cft_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hold,
  input wire logic advance,
  input wire logic restart,
  input wire logic [2:0] exp_n,
  output logic strobe
);
  cft_strobe_t r_q;
  cft_strobe_t r_d;
  logic [6:0] mask;
  logic [6:0] nxt;

  always_comb
  begin
    r_d = r_q;
    mask = 7'((8'h01 << exp_n) - 8'h01);
    nxt = restart ? 7'h00 : ((r_q.phase + 7'h01) & mask);
    if (hold)
    begin
      r_d = '0;
    end
    else if (advance)
    begin
      r_d.phase = nxt;
      r_d.strobe = (nxt == 7'h00);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign strobe = r_q.strobe;

  single_pulse_a:
  assert property (@(posedge core_clk) disable iff (!reset_n)
    advance && !restart && !hold && r_q.strobe && exp_n != 3'h0
    |=> !strobe)
    else $error("strobe held beyond one sample");
endmodule : cft_strobe_gen
`default_nettype wire

//--- rtl/cft_frame_timing.sv
// Correlator frame, accumulate and shift strobe generation
`timescale 1ns/1ps
`default_nettype none
`include "cft_defines.svh"
module cft_frame_timing
  import cft_pkg::*;
#(
  parameter int unsigned FRAME_UNIT = `CFT_FRAME_UNIT
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fmt_clk,
  input wire logic fmt_one_second_tick,
  input wire logic [3:0] upper_sideband_input,
  input wire logic [3:0] fmt_mag,
  input wire logic dec_a_clk,
  input wire logic dec_a_data,
  input wire logic dec_a_one_second_tick,
  input wire logic dec_b_clk,
  input wire logic dec_b_data,
  input wire logic dec_b_one_second_tick,
  input wire logic buf_busy,
  output logic buf_allow,
  output logic corr_active,
  output logic frame_boundary_pulse,
  output logic accumulate_strobe,
  output logic shift_strobe,
  output logic corr_sample,
  output logic [3:0] corr_sign,
  output logic [3:0] corr_mag,
  output logic [3:0] corr_valid
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decoder triple is {tick, data, clk}
  function automatic logic [2:0] dec_pick(
    input logic [`CFT_SYNC_W-1:0] v,
    input cft_src_t s
  );
    dec_pick = (s == SRC_DEC_B) ? v[`CFT_V_DECB] : v[`CFT_V_DECA];
  endfunction : dec_pick

  function automatic logic [3:0] state_hot(input logic [1:0] st);
    state_hot = 4'(4'h1 << st);
  endfunction : state_hot

  // ----------------------------------------------------------------
  // Link pin synchronisation
  // ----------------------------------------------------------------
  logic [`CFT_SYNC_W-1:0] pins;
  logic [`CFT_SYNC_W-1:0] sync_v;

  assign pins = {dec_b_one_second_tick, dec_b_data, dec_b_clk,
                 dec_a_one_second_tick, dec_a_data, dec_a_clk,
                 fmt_mag, upper_sideband_input,
                 fmt_one_second_tick, fmt_clk};

  cft_sync u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(pins),
    .sync_out(sync_v)
  );

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  cft_core_t r_q;
  cft_core_t r_d;
  cft_src_t src;
  logic [2:0] dec;
  logic s_clk;
  logic s_tick;
  logic s_data;
  logic samp;
  logic tick_ev;
  logic active;
  logic start;
  logic [`CFT_CNT_W-1:0] len;
  logic [`CFT_CNT_W-1:0] ph_nx;
  logic [1:0] ch;
  logic pick_sign;
  logic pick_mag;
  logic stb_hold;
  logic stb_adv;
  logic stb_restart;

  assign src = cft_src_t'(r_q.ctrl[`CFT_CTRL_SRC]);
  // buffer and correlator exclude each other
  assign active = r_q.ctrl[`CFT_CTRL_RUN] & ~buf_busy;
  assign len = `CFT_CNT_W'(r_q.cur_n * FRAME_UNIT);

  always_comb
  begin
    r_d = r_q;
    r_d.clr = 1'b0;
    r_d.sample = 1'b0;
    r_d.rdata = '0;
    start = 1'b0;
    stb_restart = 1'b0;
    ch = r_q.ctrl[`CFT_CTRL_CH];
    dec = dec_pick(sync_v, src);
    s_clk = (src == SRC_FMT) ? sync_v[`CFT_V_FCLK] : dec[0];
    s_data = dec[1];
    s_tick = (src == SRC_FMT) ? sync_v[`CFT_V_FTICK] : dec[2];

    if (reg_wr)
    begin
      case (reg_addr)
        `CFT_OFF_CTRL:
        begin
          r_d.ctrl = reg_wdata[7:0] & 8'h7f;
          r_d.clr = reg_wdata[`CFT_CTRL_CLEAR];
        end
        `CFT_OFF_PERIOD: r_d.period = reg_wdata[7:0];
        `CFT_OFF_STROBE: r_d.strobe_cfg = reg_wdata[7:0] & 8'h77;
        default: r_d.ctrl = r_q.ctrl;
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        `CFT_OFF_CTRL: r_d.rdata = {24'h000000, r_q.ctrl};
        `CFT_OFF_PERIOD: r_d.rdata = {24'h000000, r_q.period};
        `CFT_OFF_STROBE: r_d.rdata = {24'h000000, r_q.strobe_cfg};
        `CFT_OFF_STATUS: r_d.rdata = {16'h0000, r_q.resyncs, 1'b0,
                          r_q.realign, buf_busy, active, r_q.aligned,
                          r_q.state};
        `CFT_OFF_FRAMES: r_d.rdata = {16'h0000, r_q.frames};
        default: r_d.rdata = '0;
      endcase
    end

    r_d.clk_prev = s_clk;
    r_d.tick_prev = s_tick;
    samp = s_clk & ~r_q.clk_prev;
    tick_ev = r_q.tick_pend | (s_tick & ~r_q.tick_prev);
    // Tick latched until the sample that consumes it
    r_d.tick_pend = samp ? 1'b0 : tick_ev;
    // tick phase wraps with the frame period
    ph_nx = (tick_ev || r_q.phase == len - 25'h0000001)
      ? '0 : r_q.phase + 25'h0000001;

    if (r_q.clr || !active)
    begin
      r_d.state = ST_IDLE;
      r_d.cnt = '0;
      r_d.phase = '0;
      r_d.fbp = 1'b0;
      r_d.realign = 1'b0;
      r_d.tick_pend = 1'b0;
      r_d.aligned = 1'b0;
      if (r_q.clr)
      begin
        r_d.frames = '0;
        r_d.resyncs = '0;
      end
    end
    else if (samp)
    begin
      // edge rate bound by core clock only
      r_d.sample = 1'b1;
      r_d.phase = ph_nx;
      case (r_q.state)
        ST_IDLE:
        begin
          r_d.state = ST_WAIT;
          r_d.phase = '0;
          r_d.cur_n = 9'(r_q.period) + 9'h001;
        end
        ST_WAIT:
        begin
          start = (ph_nx == '0);
          r_d.resyncs = r_q.resyncs + {7'h00, start};
        end
        ST_RUN:
        begin
          if (r_q.cnt == len - 25'h0000001)
          begin
            r_d.frames = r_q.frames + 16'h0001;
            start = !r_q.realign || ph_nx == '0;
            if (!start)
              r_d.state = ST_WAIT;
          end
          else
          begin
            // frame never cut by a tick
            r_d.cnt = r_q.cnt + 25'h0000001;
            if (tick_ev)
              r_d.realign = 1'b1;
          end
        end
        default: r_d.state = ST_IDLE;
      endcase

      if (start)
      begin
        // new frame on tick or flywheel
        r_d.state = ST_RUN;
        r_d.cnt = '0;
        r_d.realign = 1'b0;
        r_d.aligned = tick_ev;
        r_d.cur_n = 9'(r_q.period) + 9'h001;
      end
      // high for the first 256 samples
      r_d.fbp = (r_d.state == ST_RUN) && (r_d.cnt < `CFT_PULSE_LEN);
      stb_restart = (r_d.state == ST_RUN) && (r_d.cnt == `CFT_PULSE_LEN);

      if (src == SRC_FMT)
      begin
        r_d.mux_sign = sync_v[`CFT_V_FSIGN];
        r_d.mux_mag = sync_v[`CFT_V_FMAG];
        pick_sign = 1'(sync_v[`CFT_V_FSIGN] >> ch);
        pick_mag = 1'(sync_v[`CFT_V_FMAG] >> ch);
      end
      else
      begin
        r_d.mux_sign = {4{s_data}};
        r_d.mux_mag = {4{r_q.ctrl[`CFT_CTRL_MAG]}};
        pick_sign = s_data;
        pick_mag = r_q.ctrl[`CFT_CTRL_MAG];
      end
      r_d.mux_valid = 4'hf;
      if (r_q.ctrl[`CFT_CTRL_STC])
      begin
        r_d.mux_sign = {4{pick_sign}};
        r_d.mux_mag = {4{pick_mag}};
        r_d.mux_valid = state_hot({pick_sign, pick_mag});
      end
    end
    else
    begin
      pick_sign = 1'b0;
      pick_mag = 1'b0;
    end
    if (!samp || r_q.clr || !active)
    begin
      pick_sign = 1'b0;
      pick_mag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_q <= '0;
      r_q.state <= ST_IDLE;
      r_q.ctrl <= `CFT_CTRL_RST;
      r_q.period <= `CFT_PERIOD_RST;
      r_q.strobe_cfg <= `CFT_STROBE_RST;
      r_q.cur_n <= 9'h001;
      r_q.mux_valid <= 4'hf;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Strobe generators
  // ----------------------------------------------------------------
  assign stb_hold = r_q.clr | ~active;
  assign stb_adv = samp & (r_d.state == ST_RUN);

  cft_strobe_gen u_acc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .hold(stb_hold),
    .advance(stb_adv),
    .restart(stb_restart),
    .exp_n(r_q.strobe_cfg[`CFT_ACC_N]),
    .strobe(accumulate_strobe)
  );

  cft_strobe_gen u_shf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .hold(stb_hold),
    .advance(stb_adv),
    .restart(stb_restart),
    .exp_n(r_q.strobe_cfg[`CFT_SHF_N]),
    .strobe(shift_strobe)
  );

  assign reg_rdata = r_q.rdata;
  assign frame_boundary_pulse = r_q.fbp;
  assign corr_sample = r_q.sample;
  assign corr_sign = r_q.mux_sign;
  assign corr_mag = r_q.mux_mag;
  assign corr_valid = r_q.mux_valid;
  assign corr_active = active;
  assign buf_allow = ~r_q.ctrl[`CFT_CTRL_RUN];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] h_hi;
  logic [`CFT_CNT_W-1:0] h_gap;
  logic [`CFT_CNT_W-1:0] h_len;
  logic h_prev;
  logic h_valid;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      h_hi <= '0;
      h_gap <= '0;
      h_len <= '0;
      h_prev <= 1'b0;
      h_valid <= 1'b0;
    end
    else
    begin
      h_prev <= r_q.fbp;
      if (!r_q.fbp)
        h_hi <= '0;
      else if (r_q.sample)
        h_hi <= h_hi + 9'h001;
      if (r_q.state == ST_IDLE)
        h_valid <= 1'b0;
      else if (r_q.fbp && !h_prev)
      begin
        h_valid <= 1'b1;
        h_len <= len;
      end
      if (r_q.sample)
        h_gap <= (r_q.fbp && !h_prev) ? 25'h0000001 : h_gap + 25'h0000001;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence frame_rise;
    r_q.sample && r_q.fbp && !h_prev && h_valid;
  endsequence

  sequence mid_tick;
    r_q.state == ST_RUN && samp && tick_ev && active && !r_q.clr
      && r_q.cnt != len - 25'h0000001;
  endsequence

  pulse_width_a:
  assert property ($fell(r_q.fbp) && r_q.state == ST_RUN
    |-> h_hi == 9'h100)
    else $error("frame boundary pulse not 256 samples");

  period_exact_a:
  assert property (frame_rise and $past(r_q.state) == ST_RUN
    |-> h_gap == h_len)
    else $error("flywheel frame period wrong");

  no_short_a:
  assert property (frame_rise |-> h_gap >= h_len)
    else $error("short correlator frame");

  acc_phase_a:
  assert property ($fell(r_q.fbp) && r_q.state == ST_RUN
    |-> accumulate_strobe)
    else $error("accumulate strobe low after boundary fall");

  shf_phase_a:
  assert property ($fell(r_q.fbp) && r_q.state == ST_RUN |-> shift_strobe)
    else $error("shift strobe low after boundary fall");

  acc_steady_a:
  assert property (r_q.sample && r_q.state == ST_RUN
    && r_q.strobe_cfg[`CFT_ACC_N] == 3'h0 |-> accumulate_strobe)
    else $error("accumulate strobe not held high at n of 0");

  tick_defer_a:
  assert property (mid_tick |=> r_q.state == ST_RUN && r_q.realign
    && r_q.cnt == $past(r_q.cnt) + 25'h0000001)
    else $error("mid-frame tick disturbed the frame");

  tick_start_a:
  assert property (r_q.state == ST_WAIT && samp && tick_ev && active
    && !r_q.clr |=> r_q.fbp && r_q.state == ST_RUN && r_q.aligned)
    else $error("tick did not start a frame");

  buf_lock_a:
  assert property (buf_busy |=> r_q.state == ST_IDLE && !r_q.fbp)
    else $error("correlator ran during buffer activity");

  dec_mag_a:
  assert property (r_q.sample && $past(src) != SRC_FMT
    && !$past(r_q.ctrl[`CFT_CTRL_STC])
    |-> r_q.mux_mag == {4{$past(r_q.ctrl[`CFT_CTRL_MAG])}})
    else $error("magnitude not constant for decoded stream");

  state_count_a:
  assert property (r_q.sample && $past(r_q.ctrl[`CFT_CTRL_STC])
    |-> $onehot(r_q.mux_valid) && (&r_q.mux_sign || ~|r_q.mux_sign))
    else $error("state count routing wrong");

  sync_clear_a:
  assert property (r_q.clr |=> r_q.state == ST_IDLE && r_q.cnt == '0
    && r_q.frames == 16'h0000)
    else $error("synchronous clear incomplete");
endmodule : cft_frame_timing
`default_nettype wire

//--- verif/cft_src_model.sv
// Sample-source model: link clock, data bit and second tick
`timescale 1ns/1ps
`default_nettype none
module cft_src_model #(
  parameter realtime HALF = 62.5,
  parameter realtime SKEW = 3.1
)
(
  input wire logic en,
  input wire logic gap_en,
  output logic clk,
  output logic data,
  output logic tick
);
  int n;
  task automatic send_tick();
    @(negedge clk);
    tick = 1'b1;
    repeat (2) @(negedge clk);
    tick = 1'b0;
  endtask : send_tick
  initial
  begin
    clk = 1'b0;
    data = 1'b0;
    tick = 1'b0;
    n = 0;
    #(SKEW);
    forever
    begin
      n = n + 1;
      if (en && !(gap_en && n % 8 == 0))
        clk = 1'b1;
      #(HALF);
      clk = 1'b0;
      // Pattern repeats every 8 cycles, never holds a level over two cycles
      data = n[0] ^ n[2];
      #(HALF);
    end
  end
endmodule : cft_src_model
`default_nettype wire

//--- verif/correlator_frame_timing_tb.sv
// Self-checking bench for the correlator frame timing block
`timescale 1ns/1ps
`default_nettype none
`include "cft_defines.svh"
module correlator_frame_timing_tb;
  localparam int FU = 300;
  logic core_clk, reset_n, reg_wr, reg_rd, buf_busy, dec_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] upper_sideband_input, fmt_mag;
  logic fmt_clk, fmt_tick, dec_a_clk, dec_a_data, dec_a_tick;
  logic dec_b_clk, dec_b_data, dec_b_tick;
  logic buf_allow, corr_active, frame_boundary_pulse;
  logic accumulate_strobe, shift_strobe, corr_sample;
  logic [3:0] corr_sign, corr_mag, corr_valid;
  int failures = 0;
  int n_tests = 0;
  int pos = 0, hi_cnt = 0, hi_len = 0, last_len = 0, rise_cnt = 0;
  int k = 0, since_tick = 0, sbad = 0, exp_acc = 0, exp_shf = 0;
  logic fbp_p = 1'b0, seen_fall = 1'b0, mon_en = 1'b0, tick_pend = 1'b0;

  cft_src_model #(.HALF(62.5), .SKEW(1.3)) i_fmt (.en(1'b1),
    .gap_en(1'b0), .clk(fmt_clk), .data(), .tick(fmt_tick));
  cft_src_model #(.HALF(62.5), .SKEW(7.7)) i_dec_a (.en(dec_en),
    .gap_en(1'b1), .clk(dec_a_clk), .data(dec_a_data), .tick(dec_a_tick));
  cft_src_model #(.HALF(62.5), .SKEW(40.0)) i_dec_b (.en(dec_en),
    .gap_en(1'b1), .clk(dec_b_clk), .data(dec_b_data), .tick(dec_b_tick));

  cft_frame_timing #(.FRAME_UNIT(FU)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fmt_clk(fmt_clk), .fmt_one_second_tick(fmt_tick),
    .upper_sideband_input(upper_sideband_input), .fmt_mag(fmt_mag),
    .dec_a_clk(dec_a_clk), .dec_a_data(dec_a_data),
    .dec_a_one_second_tick(dec_a_tick), .dec_b_clk(dec_b_clk),
    .dec_b_data(dec_b_data), .dec_b_one_second_tick(dec_b_tick),
    .buf_busy(buf_busy), .buf_allow(buf_allow),
    .corr_active(corr_active),
    .frame_boundary_pulse(frame_boundary_pulse),
    .accumulate_strobe(accumulate_strobe), .shift_strobe(shift_strobe),
    .corr_sample(corr_sample), .corr_sign(corr_sign),
    .corr_mag(corr_mag), .corr_valid(corr_valid));

  // ------------------------------------------------------------
  // Sample monitor
  // ------------------------------------------------------------
  always @(posedge dec_a_tick or posedge fmt_tick)
    tick_pend = 1'b1;
  // Falling edge keeps clear of the launching edge
  always @(negedge core_clk)
  begin
    if (corr_sample === 1'b1)
    begin
      since_tick = tick_pend ? 0 : since_tick + 1;
      tick_pend = 1'b0;
      pos = pos + 1;
      if (frame_boundary_pulse && !fbp_p)
      begin
        last_len = pos;
        pos = 0;
        hi_cnt = 0;
        rise_cnt = rise_cnt + 1;
      end
      if (frame_boundary_pulse)
        hi_cnt = hi_cnt + 1;
      if (!frame_boundary_pulse && fbp_p)
      begin
        hi_len = hi_cnt;
        k = 0;
        seen_fall = 1'b1;
      end
      // Strobe due whenever samples since fall hit a multiple of 2^n
      if (mon_en && seen_fall && !frame_boundary_pulse &&
          (accumulate_strobe !== (k % (1 << exp_acc) == 0) ||
           shift_strobe !== (k % (1 << exp_shf) == 0)))
        sbad = sbad + 1;
      k = k + 1;
      fbp_p = frame_boundary_pulse;
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg

  // Bounded so a dead frame counter cannot hang the run
  task automatic wait_rise();
    int r0;
    int i;
    r0 = rise_cnt;
    for (i = 0; i < 40000 && rise_cnt == r0; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk("frame start", 1, rise_cnt != r0);
  endtask : wait_rise

  task automatic wait_samples(input int n);
    int c;
    int i;
    c = 0;
    for (i = 0; i < n * 60 && c < n; i++)
    begin
      @(posedge core_clk);
      #1;
      if (corr_sample === 1'b1)
        c++;
    end
  endtask : wait_samples

  task automatic results();
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    chk("buf_allow", 1, buf_allow); // buffer free
    chk("corr_active", 0, corr_active); // idle
    rd_reg(`CFT_OFF_CTRL, d);
    chk("ctrl", 0, d);
    rd_reg(`CFT_OFF_STATUS, d);
    chk("status", 1, d);
    rd_reg(8'h14, d);
    chk("unmapped", 0, d);
    wr_reg(`CFT_OFF_PERIOD, 32'h2a);
    rd_reg(`CFT_OFF_PERIOD, d);
    chk("period", 32'h2a, d);
  endtask : t_regs

  task automatic t_excl();
    logic [31:0] d;
    wr_reg(`CFT_OFF_CTRL, 32'h1);
    @(posedge core_clk);
    buf_busy <= 1'b1;
    #1;
    chk("buf_allow run", 0, buf_allow); // blocked
    @(posedge core_clk);
    #1;
    chk("corr_active busy", 0, corr_active); // disabled
    rd_reg(`CFT_OFF_STATUS, d);
    chk("status busy", 32'h2, d[5:4]); // flags
    @(posedge core_clk);
    buf_busy <= 1'b0;
    #1;
    chk("corr_active", 1, corr_active); // enabled
    wr_reg(`CFT_OFF_CTRL, 32'h80);
  endtask : t_excl

  task automatic t_fmt();
    logic [31:0] d;
    exp_acc = 2;
    exp_shf = 5;
    @(posedge core_clk);
    upper_sideband_input <= 4'ha;
    fmt_mag <= 4'h5;
    wr_reg(`CFT_OFF_PERIOD, 32'h0); // whole frames per second
    wr_reg(`CFT_OFF_STROBE, 32'h52);
    wr_reg(`CFT_OFF_CTRL, 32'h1);
    wait_rise(); // flywheel start
    sbad = 0;
    seen_fall = 1'b0;
    mon_en = 1'b1;
    wait_rise();
    wait_rise();
    chk("frame len", FU, last_len); // period
    chk("pulse len", 256, hi_len); // width
    chk("strobes", 0, sbad); // phase
    chk("sign", 32'ha, corr_sign); // lanes
    chk("mag", 32'h5, corr_mag); // lanes
    rd_reg(`CFT_OFF_FRAMES, d); // once per frame
    chk("frames", 2, d); // frame count
    mon_en = 1'b0;
    wr_reg(`CFT_OFF_CTRL, 32'h80);
    @(posedge core_clk);
    #1;
    chk("fbp clear", 0, frame_boundary_pulse); // clear
    rd_reg(`CFT_OFF_STATUS, d);
    chk("state clear", 1, d[2:0]); // idle
    rd_reg(`CFT_OFF_FRAMES, d);
    chk("frames clear", 0, d); // count
  endtask : t_fmt

  task automatic t_state();
    int s;
    wr_reg(`CFT_OFF_CTRL, 32'h51);
    for (s = 0; s < 4; s++)
    begin
      @(posedge core_clk);
      upper_sideband_input <= s[1] ? 4'h4 : 4'hb;
      fmt_mag <= s[0] ? 4'h4 : 4'hb;
      wait_samples(8);
      chk("valid", 4'h1 << (2 * s[1] + s[0]), corr_valid); // state
      chk("sc sign", {4{s[1]}}, corr_sign); // copy
      chk("sc mag", {4{s[0]}}, corr_mag); // copy
    end
    wr_reg(`CFT_OFF_CTRL, 32'h80);
  endtask : t_state

  task automatic t_dec();
    exp_acc = 0;
    exp_shf = 7;
    @(posedge core_clk);
    dec_en <= 1'b1;
    wr_reg(`CFT_OFF_PERIOD, 32'h1);
    wr_reg(`CFT_OFF_STROBE, 32'h70);
    wr_reg(`CFT_OFF_CTRL, 32'h0b);
    wait_samples(4);
    // Tick frame rises before the tick task returns
    fork
      i_dec_a.send_tick();
      begin
        wait_rise();
        chk("start on tick", 0, since_tick); // align
      end
    join
    sbad = 0;
    seen_fall = 1'b0;
    mon_en = 1'b1;
    wait_rise();
    chk("dec len", 2 * FU, last_len); // real edges
    chk("dec pulse", 256, hi_len); // width
    chk("dec mag", 32'hf, corr_mag); // held level
    chk("dec sign", 1, corr_sign === 4'h0 || corr_sign === 4'hf);
    wait_samples(300);
    // Strobes are frozen while waiting for tick phase
    mon_en = 1'b0;
    chk("dec strobes", 0, sbad); // phase
    i_dec_a.send_tick();
    wait_rise();
    chk("realign", 2 * FU, since_tick); // tick phase
    chk("no short", 1, last_len >= 2 * FU); // length
    wait_rise();
    chk("full frame", 2 * FU, last_len); // not cut
    wr_reg(`CFT_OFF_CTRL, 32'h80);
    wr_reg(`CFT_OFF_CTRL, 32'h05);
    wait_samples(8);
    chk("dec b mag", 0, corr_mag); // second decoder
    @(posedge core_clk);
    dec_en <= 1'b0;
    wr_reg(`CFT_OFF_CTRL, 32'h80);
  endtask : t_dec

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #490000;
    failures++;
    results();
  end

  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    buf_busy = 1'b0;
    dec_en = 1'b0;
    upper_sideband_input = 4'h0;
    fmt_mag = 4'h0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_excl();
    t_fmt();
    t_state();
    t_dec();
    results();
  end
endmodule : correlator_frame_timing_tb
`default_nettype wire
